// ---- hdl/qdc_pkg.sv ----
// What this block does
// RULE1 - Writing one to an interrupt-clear bit disables that event's interrupt, bits zero to four.
// RULE2 - Writing zero leaves the enable alone; reads return enables, one meaning enabled.
// RULE3 - Report-ready fires after the report period only when the motion tally is nonzero.
// RULE4 - Double-ready fires after the report period only when the double tally is nonzero.
// RULE5 - Enable one claims the decoder pins; enable zero frees them for general use.
// RULE6 - Lamp polarity zero lights the lamp with a low pin, one with high.
// RULE7 - Sample interval is 128 us times two to the code, codes zero to ten.
// RULE8 - The last motion sample is refreshed once for every sample taken.
// RULE9 - Writing one to an interrupt-set bit enables that event, same bit layout.
// RULE10 - The sample is signed two's complement; value two marks a double transition.
package qdc_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned SAMPLE_BASE_US = 128;
  localparam int unsigned SAMPLE_BASE_CYC = SAMPLE_BASE_US * (CLK_HZ / 1_000_000);
  localparam logic [3:0] SAMPLE_CODE_MAX = 4'hA;

  // ==========================================================================
  // Register byte offsets
  localparam logic [11:0] OFS_TASK_START = 12'h000;
  localparam logic [11:0] OFS_TASK_STOP = 12'h004;
  localparam logic [11:0] OFS_TASK_SNAP = 12'h008;
  localparam logic [11:0] OFS_EVENT_STATUS = 12'h100;
  localparam logic [11:0] OFS_INT_SET = 12'h304;
  localparam logic [11:0] OFS_INT_CLEAR = 12'h308;
  localparam logic [11:0] OFS_DECODER_ON = 12'h500;
  localparam logic [11:0] OFS_LAMP_POL = 12'h504;
  localparam logic [11:0] OFS_SAMPLE_INT = 12'h508;
  localparam logic [11:0] OFS_SAMPLE = 12'h50C;
  localparam logic [11:0] OFS_REPORT_PER = 12'h510;
  localparam logic [11:0] OFS_TALLY = 12'h514;
  localparam logic [11:0] OFS_TALLY_SNAP = 12'h518;
  localparam logic [11:0] OFS_DBL_TALLY = 12'h544;
  localparam logic [11:0] OFS_DBL_SNAP = 12'h548;

  // ==========================================================================
  // Event bit positions, shared by status, set and clear registers
  localparam int EV_SAMPLE = 0;
  localparam int EV_REPORT = 1;
  localparam int EV_OVERFLOW = 2;
  localparam int EV_DOUBLE = 3;
  localparam int EV_STOPPED = 4;
  localparam int EV_W = 5;

  // ==========================================================================
  // Field widths and reset values
  localparam int TALLY_W = 16;
  localparam int DBL_W = 4;
  localparam int RPT_W = 8;
  localparam logic [EV_W-1:0] INT_EN_RST = 5'h00;
  localparam logic [3:0] SAMPLE_INT_RST = 4'h0;
  localparam logic [RPT_W-1:0] REPORT_PER_RST = 8'h0A;

  typedef enum logic [1:0] {
    QDC_IDLE = 2'b01,
    QDC_RUN = 2'b10
  } qdc_state_t;

endpackage

// ---- hdl/qdc_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module qdc_sync import qdc_pkg::*; (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [1:0] pin_i,
  output logic [1:0] level_o
);

  // ==========================================================================
  // Three stages per pin; the level moves once stages two and three agree.
  genvar g;
  for (g = 0; g < 2; g++) begin : g_pin
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic lvl_q;
    wire agree = (s2_q == s3_q);
    always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        s1_q <= 1'b0;
        s2_q <= 1'b0;
        s3_q <= 1'b0;
        lvl_q <= 1'b0;
      end else begin
        s1_q <= pin_i[g];
        s2_q <= s1_q;
        s3_q <= s2_q;
        lvl_q <= agree ? s3_q : lvl_q;
      end
    end
    assign level_o[g] = lvl_q;
  end

endmodule
`default_nettype wire

// ---- hdl/qdc_top.sv ----
// Chosen here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module qdc_top #(
  parameter int unsigned SAMPLE_BASE_CYC = qdc_pkg::SAMPLE_BASE_CYC
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic enc_a_i,
  input wire logic enc_b_i,
  output logic lamp_o,
  output logic pins_claim_o,
  output logic irq_o
);
  import qdc_pkg::*;

  // ==========================================================================
  // Declarations
  qdc_state_t state_q;
  qdc_state_t state_d;
  logic [EV_W-1:0] int_en_q;
  logic [EV_W-1:0] int_en_d;
  logic [EV_W-1:0] status_q;
  logic [EV_W-1:0] status_d;
  logic [EV_W-1:0] events;
  logic decoder_on_q;
  logic lamp_pol_q;
  logic [3:0] sample_int_q;
  logic [RPT_W-1:0] report_per_q;
  logic signed [2:0] sample_q;
  logic signed [TALLY_W-1:0] tally_q;
  logic signed [TALLY_W-1:0] tally_d;
  logic signed [TALLY_W-1:0] tally_snap_q;
  logic [DBL_W-1:0] dbl_q;
  logic [DBL_W-1:0] dbl_d;
  logic [DBL_W-1:0] dbl_snap_q;
  logic [31:0] tick_cnt_q;
  logic [RPT_W-1:0] rpt_cnt_q;
  logic [1:0] prev_ab_q;
  logic [1:0] pin_lvl;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic lamp_q;
  logic irq_q;
  logic [31:0] rd_val;
  logic rd_hit;
  logic decoder_on_d;
  logic lamp_pol_d;
  logic [3:0] sample_int_d;
  logic [RPT_W-1:0] report_per_d;
  logic irq_d;
  logic [31:0] tick_cnt_d;
  logic [RPT_W-1:0] rpt_cnt_d;
  logic [1:0] prev_ab_d;
  logic signed [2:0] sample_d;
  logic signed [TALLY_W-1:0] tally_snap_d;
  logic [DBL_W-1:0] dbl_snap_d;
  logic lamp_d;
  logic pready_d;
  logic pslverr_d;
  logic [31:0] prdata_d;

  // ==========================================================================
  // Pin synchroniser
  qdc_sync u_sync (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .pin_i({enc_a_i, enc_b_i}),
    .level_o(pin_lvl)
  );

  // ==========================================================================
  // Quadrature step: Gray order 00, 01, 11, 10 counts forward.
  function automatic logic signed [2:0] qdc_step(input logic [1:0] p, input logic [1:0] c);
    logic signed [2:0] r;
    r = 3'sd0;
    if (p == c) begin
      r = 3'sd0;
    end else if ((p ^ c) == 2'b11) begin
      r = 3'sd2;
    end else if ({p, c} == 4'b0001 || {p, c} == 4'b0111 || {p, c} == 4'b1110 || {p, c} == 4'b1000) begin
      r = 3'sd1;
    end else begin
      r = -3'sd1;
    end
    return r;
  endfunction

  // ==========================================================================
  // Bus decode
  wire setup = psel_i && !penable_i;
  wire wr_en = psel_i && penable_i && pwrite_i && pready_q;
  wire wr_ok = wr_en && !pslverr_q;
  wire wr_start = wr_ok && (paddr_i == OFS_TASK_START) && pwdata_i[0];
  wire wr_stop = wr_ok && (paddr_i == OFS_TASK_STOP) && pwdata_i[0];
  wire wr_snap = wr_ok && (paddr_i == OFS_TASK_SNAP) && pwdata_i[0];
  wire wr_status = wr_ok && (paddr_i == OFS_EVENT_STATUS);
  wire wr_int_set = wr_ok && (paddr_i == OFS_INT_SET);
  wire wr_int_clr = wr_ok && (paddr_i == OFS_INT_CLEAR);
  wire wr_on = wr_ok && (paddr_i == OFS_DECODER_ON);
  wire wr_pol = wr_ok && (paddr_i == OFS_LAMP_POL);
  wire wr_int = wr_ok && (paddr_i == OFS_SAMPLE_INT);
  wire wr_rpt = wr_ok && (paddr_i == OFS_REPORT_PER);
  wire [EV_W-1:0] wmask = pwdata_i[EV_W-1:0];

  // ==========================================================================
  // Sample timer; codes above ten are held at ten.
  wire [3:0] code = (sample_int_q > SAMPLE_CODE_MAX) ? SAMPLE_CODE_MAX : sample_int_q;
  wire [31:0] period = SAMPLE_BASE_CYC[31:0] << code; // see RULE7
  wire running = (state_q == QDC_RUN);
  wire tick = running && (tick_cnt_q >= period - 32'h0000_0001);

  // ==========================================================================
  // Decoding and tallies
  wire signed [2:0] step = qdc_step(prev_ab_q, pin_lvl); // see RULE10
  wire is_double = (step == 3'sd2);
  wire signed [TALLY_W:0] tally_base = wr_snap ? '0 : {tally_q[TALLY_W-1], tally_q};
  wire signed [TALLY_W:0] step_ext = is_double ? '0 : {{(TALLY_W-2){step[2]}}, step};
  wire signed [TALLY_W:0] tally_sum = tally_base + step_ext;
  wire tally_ovf = tick && (tally_sum[TALLY_W] != tally_sum[TALLY_W-1]);
  wire [DBL_W-1:0] dbl_base = wr_snap ? '0 : dbl_q;
  wire dbl_full = (dbl_base == {DBL_W{1'b1}});
  wire [RPT_W-1:0] per_eff = (report_per_q == '0) ? {{(RPT_W-1){1'b0}}, 1'b1} : report_per_q;
  wire rpt_done = tick && (rpt_cnt_q + 1'b1 >= per_eff);

  always_comb begin
    tally_d = tally_base[TALLY_W-1:0];
    dbl_d = dbl_base;
    if (tick && !tally_ovf) begin
      tally_d = tally_sum[TALLY_W-1:0];
    end
    if (tick && is_double && !dbl_full) begin
      dbl_d = dbl_base + 1'b1;
    end
  end

  // ==========================================================================
  // Events
  always_comb begin
    events = '0;
    events[EV_SAMPLE] = tick;
    events[EV_REPORT] = rpt_done && (tally_d != '0); // see RULE3
    events[EV_OVERFLOW] = tally_ovf;
    events[EV_DOUBLE] = rpt_done && (dbl_d != '0); // see RULE4
    events[EV_STOPPED] = running && (wr_stop || (wr_on && !pwdata_i[0]));
  end

  // A new event in the clear cycle keeps its bit set.
  assign status_d = (status_q & ~(wr_status ? wmask : '0)) | events;

  always_comb begin
    int_en_d = int_en_q;
    if (wr_int_set) begin
      int_en_d = int_en_q | wmask; // see RULE9
    end else if (wr_int_clr) begin
      int_en_d = int_en_q & ~wmask; // see RULE1 see RULE2
    end
  end

  // ==========================================================================
  // Run control; sampling starts only while the decoder owns the pins and stops one cycle after it frees them.
  always_comb begin
    state_d = state_q;
    case (state_q)
      QDC_IDLE: begin
        if (wr_start && decoder_on_q) begin
          state_d = QDC_RUN;
        end
      end
      QDC_RUN: begin
        if (wr_stop || !decoder_on_q) begin
          state_d = QDC_IDLE;
        end
      end
      default: begin
        state_d = QDC_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // Read mux
  always_comb begin
    rd_val = '0;
    rd_hit = 1'b1;
    if (paddr_i == OFS_TASK_START || paddr_i == OFS_TASK_STOP || paddr_i == OFS_TASK_SNAP) begin
      rd_val = '0;
    end else if (paddr_i == OFS_EVENT_STATUS) begin
      rd_val[EV_W-1:0] = status_q;
    end else if (paddr_i == OFS_INT_SET || paddr_i == OFS_INT_CLEAR) begin
      rd_val[EV_W-1:0] = int_en_q; // see RULE2
    end else if (paddr_i == OFS_DECODER_ON) begin
      rd_val[0] = decoder_on_q;
    end else if (paddr_i == OFS_LAMP_POL) begin
      rd_val[0] = lamp_pol_q;
    end else if (paddr_i == OFS_SAMPLE_INT) begin
      rd_val[3:0] = sample_int_q;
    end else if (paddr_i == OFS_SAMPLE) begin
      rd_val = {{29{sample_q[2]}}, sample_q}; // see RULE10
    end else if (paddr_i == OFS_REPORT_PER) begin
      rd_val[RPT_W-1:0] = report_per_q;
    end else if (paddr_i == OFS_TALLY) begin
      rd_val = {{(32-TALLY_W){tally_q[TALLY_W-1]}}, tally_q};
    end else if (paddr_i == OFS_TALLY_SNAP) begin
      rd_val = {{(32-TALLY_W){tally_snap_q[TALLY_W-1]}}, tally_snap_q};
    end else if (paddr_i == OFS_DBL_TALLY) begin
      rd_val[DBL_W-1:0] = dbl_q;
    end else if (paddr_i == OFS_DBL_SNAP) begin
      rd_val[DBL_W-1:0] = dbl_snap_q;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // ==========================================================================
  // Bus answer: no wait state, data and error caught in the setup cycle.
  assign pready_d = setup;
  assign pslverr_d = setup && !rd_hit;
  assign prdata_d = (setup && !pwrite_i) ? rd_val : 32'h0000_0000;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  // ==========================================================================
  // Configuration and interrupt state
  assign decoder_on_d = wr_on ? pwdata_i[0] : decoder_on_q;
  assign lamp_pol_d = wr_pol ? pwdata_i[0] : lamp_pol_q;
  assign sample_int_d = wr_int ? pwdata_i[3:0] : sample_int_q;
  assign report_per_d = wr_rpt ? pwdata_i[RPT_W-1:0] : report_per_q;
  assign irq_d = |(status_d & int_en_d);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      int_en_q <= INT_EN_RST;
      status_q <= '0;
      irq_q <= 1'b0;
    end else begin
      int_en_q <= int_en_d;
      status_q <= status_d;
      irq_q <= irq_d;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      decoder_on_q <= 1'b0;
      lamp_pol_q <= 1'b0;
      sample_int_q <= SAMPLE_INT_RST;
      report_per_q <= REPORT_PER_RST;
    end else begin
      decoder_on_q <= decoder_on_d;
      lamp_pol_q <= lamp_pol_d;
      sample_int_q <= sample_int_d;
      report_per_q <= report_per_d;
    end
  end

  // ==========================================================================
  // Sampling state
  // A new sample interval acts on the running count, so the first sample after a change may come early.
  assign tick_cnt_d = (tick || !running) ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
  assign rpt_cnt_d = (rpt_done || !running) ? '0 : (tick ? rpt_cnt_q + 1'b1 : rpt_cnt_q);
  assign prev_ab_d = (tick || !running) ? pin_lvl : prev_ab_q;
  assign sample_d = tick ? step : sample_q; // see RULE8
  // A snapshot copies the tallies as they stood before this cycle's clear.
  assign tally_snap_d = wr_snap ? tally_q : tally_snap_q;
  assign dbl_snap_d = wr_snap ? dbl_q : dbl_snap_q;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= QDC_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tick_cnt_q <= 32'h0000_0000;
      rpt_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      rpt_cnt_q <= rpt_cnt_d;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prev_ab_q <= 2'b00;
      sample_q <= 3'sd0;
    end else begin
      prev_ab_q <= prev_ab_d;
      sample_q <= sample_d;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tally_q <= '0;
      dbl_q <= '0;
    end else begin
      tally_q <= tally_d;
      dbl_q <= dbl_d;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tally_snap_q <= '0;
      dbl_snap_q <= '0;
    end else begin
      tally_snap_q <= tally_snap_d;
      dbl_snap_q <= dbl_snap_d;
    end
  end

  // ==========================================================================
  // Pin drive; the lamp is lit while sampling runs.
  assign lamp_d = ~(running ^ lamp_pol_q); // see RULE6

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lamp_q <= 1'b1;
    end else begin
      lamp_q <= lamp_d;
    end
  end

  assign pins_claim_o = decoder_on_q; // see RULE5
  assign lamp_o = lamp_q;
  assign irq_o = irq_q;
  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;

endmodule
`default_nettype wire

// ---- verif/qdc_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module qdc_monitor import qdc_pkg::*; (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic enc_a_i,
  input wire logic enc_b_i,
  input wire logic lamp_o,
  input wire logic pins_claim_o,
  input wire logic irq_o
);
  // ==========================================================================
  // Shadow copies of the enables and the lamp polarity.
  logic [4:0] en_q;
  logic pol_q;
  wire wr = psel_i && penable_i && pwrite_i && pready_o && !pslverr_o;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      en_q <= INT_EN_RST;
      pol_q <= 1'b0;
    end else if (wr) begin
      if (paddr_i == OFS_INT_SET) en_q <= en_q | pwdata_i[4:0];
      if (paddr_i == OFS_INT_CLEAR) en_q <= en_q & ~pwdata_i[4:0];
      if (paddr_i == OFS_LAMP_POL) pol_q <= pwdata_i[0];
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  chk_ready_setup: assert property (psel_i && !penable_i |=> pready_o) else $error("no ready after setup");
  chk_ready_pulse: assert property (pready_o |=> !pready_o) else $error("ready held too long");
  chk_err_ready: assert property (pslverr_o |-> pready_o) else $error("error without ready");
  chk_err_unmapped: assert property (pready_o && paddr_i == 12'h0FFC |-> pslverr_o) else $error("unmapped ok");
  chk_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0000_0000) else $error("read data not idle");
  chk_claim_write: assert property (wr && paddr_i == OFS_DECODER_ON |=> pins_claim_o == $past(pwdata_i[0]))
    else $error("claim not written");
  chk_claim_hold: assert property (!(wr && paddr_i == OFS_DECODER_ON) |=> $stable(pins_claim_o))
    else $error("claim moved");
  chk_irq_masked: assert property (en_q == 5'h00 && !(wr && paddr_i == OFS_INT_SET) |=> !irq_o)
    else $error("irq while all masked");
  chk_irq_enable: assert property (irq_o |-> en_q != 5'h00) else $error("irq without enable");
  chk_lamp_idle: assert property (!pins_claim_o [*3] ##0 $stable(pol_q) |-> lamp_o == !pol_q)
    else $error("lamp lit while idle");
endmodule
bind qdc_top qdc_monitor i_qdc_monitor (.clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .enc_a_i(enc_a_i), .enc_b_i(enc_b_i), .lamp_o(lamp_o),
  .pins_claim_o(pins_claim_o), .irq_o(irq_o));
`default_nettype wire

// ---- verif/qdc_encoder_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module qdc_encoder_model (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic go_i,
  input wire logic [1:0] cmd_i,
  output logic enc_a_o,
  output logic enc_b_o
);
  // ==========================================================================
  // Shaft position; command 1 steps forward, 2 back, 3 jumps two phases.
  logic [1:0] pos_q;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) pos_q <= 2'h0;
    else if (go_i) pos_q <= pos_q + ((cmd_i == 2'h2) ? 2'h3 : ((cmd_i == 2'h3) ? 2'h2 : cmd_i));
  end
  assign enc_a_o = pos_q[1];
  assign enc_b_o = pos_q[1] ^ pos_q[0];
endmodule
`default_nettype wire

// ---- verif/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
  import qdc_pkg::*;
  logic clk, resetn, psel, penable, pwrite, go, enc_a, enc_b, lamp, claim, irq, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [1:0] cmd;
  logic e;
  int n_errors = 0;
  int compares = 0;
  int cyc = 0;
  int t0, t1;
  int codes [3] = '{2, 3, 10};
  logic [1:0] steps [3] = '{2'h1, 2'h2, 2'h3};
  logic [31:0] smp [3] = '{32'h0000_0001, 32'hFFFF_FFFF, 32'h0000_0002};
  logic [31:0] sts [3] = '{32'h0000_0003, 32'h0000_0001, 32'h0000_0009};
  logic [11:0] regs [4] = '{OFS_INT_CLEAR, OFS_DECODER_ON, OFS_LAMP_POL, OFS_SAMPLE_INT};
  qdc_top #(.SAMPLE_BASE_CYC(4)) i_qdc_top (.clk_i(clk), .resetn_i(resetn), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .enc_a_i(enc_a), .enc_b_i(enc_b), .lamp_o(lamp), .pins_claim_o(claim), .irq_o(irq));
  qdc_encoder_model i_qdc_encoder_model (.clk_i(clk), .resetn_i(resetn), .go_i(go), .cmd_i(cmd),
    .enc_a_o(enc_a), .enc_b_o(enc_b));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  // ==========================================================================
  // Bus access and checking helpers.
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) n_errors++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check($sformatf("reg %h", a), r, exp);
  endtask
  task automatic wait_irq();
    int n;
    n = 0;
    repeat (2) @(posedge clk);
    while (irq !== 1'b1 && n < 20000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 20000) n_errors++;
    t1 = cyc;
  endtask
  task automatic step(input logic [1:0] c);
    @(posedge clk);
    cmd <= c;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask
  task automatic conclude();
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    conclude();
  end
  // ==========================================================================
  // Test sequence.
  initial begin
    {resetn, psel, penable, pwrite, go} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    cmd = 2'h0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    foreach (regs[i]) rd_chk(regs[i], 32'h0000_0000);
    rd_chk(12'h0FFC, 32'h0000_0000);
    check("unmapped error", 32'(e), 32'h0000_0001);
    apb(1'b1, OFS_INT_SET, 32'h0000_001F);
    rd_chk(OFS_INT_CLEAR, 32'h0000_001F);
    apb(1'b1, OFS_INT_CLEAR, 32'h0000_0015);
    rd_chk(OFS_INT_SET, 32'h0000_000A);
    apb(1'b1, OFS_INT_CLEAR, 32'h0000_0000);
    rd_chk(OFS_INT_CLEAR, 32'h0000_000A);
    apb(1'b1, OFS_INT_CLEAR, 32'h0000_001E);
    apb(1'b1, OFS_INT_SET, 32'h0000_0001);
    rd_chk(OFS_INT_CLEAR, 32'h0000_0001);
    apb(1'b1, OFS_DECODER_ON, 32'h0000_0001);
    @(posedge clk);
    check("claim", 32'(claim), 32'h0000_0001);
    apb(1'b1, OFS_REPORT_PER, 32'h0000_0001);
    apb(1'b1, OFS_TASK_START, 32'h0000_0001);
    repeat (2) @(posedge clk);
    check("lamp", 32'(lamp), 32'h0000_0000);
    foreach (codes[i]) begin
      apb(1'b1, OFS_SAMPLE_INT, 32'(codes[i]));
      rd_chk(OFS_SAMPLE_INT, 32'(codes[i]));
      wait_irq();
      apb(1'b1, OFS_EVENT_STATUS, 32'h0000_001F);
      wait_irq();
      t0 = t1;
      apb(1'b1, OFS_EVENT_STATUS, 32'h0000_001F);
      wait_irq();
      check("period", 32'(t1 - t0), 32'(4 << codes[i]));
    end
    apb(1'b1, OFS_SAMPLE_INT, 32'h0000_0004);
    foreach (steps[i]) begin
      apb(1'b1, OFS_EVENT_STATUS, 32'h0000_001F);
      wait_irq();
      apb(1'b1, OFS_EVENT_STATUS, 32'h0000_001F);
      step(steps[i]);
      wait_irq();
      rd_chk(OFS_SAMPLE, smp[i]);
      rd_chk(OFS_EVENT_STATUS, sts[i]);
    end
    rd_chk(OFS_TALLY, 32'h0000_0000);
    rd_chk(OFS_DBL_TALLY, 32'h0000_0001);
    apb(1'b1, OFS_INT_CLEAR, 32'h0000_0001);
    apb(1'b1, OFS_EVENT_STATUS, 32'h0000_001F);
    repeat (200) @(posedge clk);
    check("masked irq", 32'(irq), 32'h0000_0000);
    rd_chk(OFS_EVENT_STATUS, 32'h0000_0009);
    apb(1'b1, OFS_TASK_SNAP, 32'h0000_0001);
    rd_chk(OFS_DBL_SNAP, 32'h0000_0001);
    rd_chk(OFS_DBL_TALLY, 32'h0000_0000);
    apb(1'b1, OFS_EVENT_STATUS, 32'h0000_001F);
    repeat (200) @(posedge clk);
    rd_chk(OFS_EVENT_STATUS, 32'h0000_0001);
    apb(1'b1, OFS_TASK_STOP, 32'h0000_0001);
    rd_chk(OFS_EVENT_STATUS, 32'h0000_0011);
    apb(1'b1, OFS_LAMP_POL, 32'h0000_0001);
    apb(1'b1, OFS_TASK_START, 32'h0000_0001);
    repeat (2) @(posedge clk);
    check("lamp", 32'(lamp), 32'h0000_0001);
    apb(1'b1, OFS_DECODER_ON, 32'h0000_0000);
    repeat (3) @(posedge clk);
    check("claim", 32'(claim), 32'h0000_0000);
    check("lamp", 32'(lamp), 32'h0000_0000);
    conclude();
  end
endmodule
`default_nettype wire
